//--- hw/spi_slave_pkg.sv
/*
 * Shared constants and types for the serial peripheral slave: register
 * offsets, control field layout, reset values, edge counts and states.
 * Assumes a single 100 MHz module clock and a byte-addressed register port.
 */
package spi_slave_pkg;

    // ==========================================================
    // Register port
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  OFF_CONTROL     = 8'h00;
    localparam logic [7:0]  OFF_DATA        = 8'h04;
    localparam logic [7:0]  OFF_STATUS      = 8'h08;

    // ==========================================================
    // Control register field positions
    localparam int          POS_MASTER_SELECT   = 0;
    localparam int          POS_CPOL            = 1;
    localparam int          POS_CPHA            = 2;
    localparam int          POS_LSB_FIRST       = 3;
    localparam int          POS_WORD_WIDTH      = 4;
    localparam int          POS_SINGLE_WIRE     = 5;
    localparam int          POS_SINGLE_WIRE_OE  = 6;
    localparam int          POS_SELECT_OE       = 7;
    localparam int          POS_FAULT_DETECT    = 8;
    localparam int          CTRL_W              = 9;
    localparam logic [8:0]  CTRL_RESET          = 9'h000;

    // Status register field positions
    localparam int          POS_DONE            = 0;
    localparam int          POS_BUSY            = 1;

    // ==========================================================
    // Word geometry
    localparam int          WORD_MAX        = 16;
    localparam logic [15:0] DATA_RESET      = 16'h0000;
    localparam int          CNT_W           = 6;
    localparam logic [5:0]  EDGES_NARROW    = 6'h10;
    localparam logic [5:0]  EDGES_WIDE      = 6'h20;

    // ==========================================================
    // Types
    typedef struct packed {
        logic fault_detect_enable;
        logic select_output_enable;
        logic single_wire_output_enable;
        logic single_wire_mode;
        logic word_width_select;
        logic lsb_first;
        logic cpha;
        logic cpol;
        logic master_select;
    } ctrl_t;

    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_ACTIVE = 1'b1
    } xfer_state_t;

    typedef struct packed {
        logic sck;
        logic ss_n;
        logic mosi;
        logic miso;
    } pins_t;

endpackage

//--- hw/sync_2ff.sv
/*
 * Two-stage synchroniser for a vector of asynchronous levels.
 * Assumes each bit is an independent level; the first stage is read
 * only by the second stage.
 */
`timescale 1ns/1ns
module sync_2ff #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_t;

    sync_t cur;
    sync_t next_cur;

    initial begin
        if (W < 1) begin
            $error("sync_2ff: width must be at least one");
        end
    end

    always_comb begin
        next_cur        = cur;
        next_cur.meta   = d;
        next_cur.stable = cur.meta;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign q = cur.stable;

endmodule

//--- hw/spi_slave_transfer.sv
/*
 * Serial peripheral slave: shift engine for both clock phases, select
 * handling, double-buffered reception and the register port.
 * Assumes an external master drives sck, ss_n and mosi asynchronously,
 * at a bit rate well below a quarter of the module clock.
 */
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module spi_slave_transfer
    import spi_slave_pkg::*;
#(
    parameter int WORD_W = WORD_MAX
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              we,
    input  wire logic              re,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              sck,
    input  wire logic              ss_n,
    input  wire logic              mosi,
    input  wire logic              miso_i,
    output logic                   miso_o,
    output logic                   miso_oe_n,
    output logic                   transfer_done_flag
);

    // ==========================================================
    // State
    typedef struct packed {
        xfer_state_t         state;
        logic [CNT_W-1:0]    edge_cnt;
        logic [WORD_MAX-1:0] shreg;
        logic                latched;
        logic                out_bit;
        logic                drive;
        logic                sck_prev;
        ctrl_t               ctrl;
        logic [WORD_MAX-1:0] tx_data;
        logic [WORD_MAX-1:0] rx_data;
        logic                done;
        logic [DATA_W-1:0]   rdata;
    } slave_state_t;

    slave_state_t cur;
    slave_state_t next_cur;
    pins_t        pin_raw;
    pins_t        pin_s;

    initial begin
        if (WORD_W != WORD_MAX) begin
            $error("spi_slave_transfer: only a 16-bit shift register is supported");
        end
    end

    // ==========================================================
    // Pin synchronisation
    assign pin_raw.sck  = sck;
    assign pin_raw.ss_n = ss_n;
    assign pin_raw.mosi = mosi;
    assign pin_raw.miso = miso_i;

    sync_2ff #(
        .W      (4)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (pin_raw),
        .q      (pin_s)
    );

    // ==========================================================
    // Word helpers
    function automatic logic first_bit(input logic [WORD_MAX-1:0] sh,
                                       input logic                wide,
                                       input logic                lsb);
        logic r;
        r = 1'b0;
        if (lsb) begin
            r = sh[0];
        end else if (wide) begin
            r = sh[15];
        end else begin
            r = sh[7];
        end
        return r;
    endfunction

    function automatic logic [WORD_MAX-1:0] shift_in(input logic [WORD_MAX-1:0] sh,
                                                     input logic                b,
                                                     input logic                wide,
                                                     input logic                lsb);
        logic [WORD_MAX-1:0] r;
        r = sh;
        if (!lsb) begin
            r = {sh[14:0], b};
        end else if (wide) begin
            r = {b, sh[15:1]};
        end else begin
            r = {8'h00, b, sh[7:1]};
        end
        return r;
    endfunction

    // ==========================================================
    // Next-state logic
    logic                slave_mode;
    logic                selected;
    logic                sck_edge;
    logic                serial_in;
    logic [CNT_W-1:0]    edge_num;
    logic [CNT_W-1:0]    last_edge;
    logic                odd_edge;
    logic                wide;
    logic                lsb;
    logic [WORD_MAX-1:0] word_mask;
    logic [WORD_MAX-1:0] shifted;
    logic                finished;

    always_comb begin
        next_cur   = cur;
        slave_mode = !cur.ctrl.master_select;
        selected   = slave_mode && !pin_s.ss_n;
        // Any transition counts, so polarity never moves the acting edges
        sck_edge   = pin_s.sck ^ cur.sck_prev;
        // Single-wire slave listens on its own output pin
        serial_in  = cur.ctrl.single_wire_mode ? pin_s.miso : pin_s.mosi;
        wide       = cur.ctrl.word_width_select;
        lsb        = cur.ctrl.lsb_first;
        last_edge  = wide ? EDGES_WIDE : EDGES_NARROW;
        word_mask  = wide ? 16'hffff : 16'h00ff;
        edge_num   = cur.edge_cnt + 6'h01;
        odd_edge   = edge_num[0];
        shifted    = shift_in(cur.shreg, cur.latched, wide, lsb);
        finished   = 1'b0;

        next_cur.sck_prev = pin_s.sck;

        // Pin driver: released unless selected and pointed outward
        next_cur.drive = selected &&
                         (!cur.ctrl.single_wire_mode || cur.ctrl.single_wire_output_enable);

        case (cur.state)
            ST_IDLE: begin
                next_cur.edge_cnt = '0;
                if (selected) begin
                    // A fresh select loads the software word
                    next_cur.shreg   = cur.tx_data & word_mask;
                    next_cur.out_bit = cur.ctrl.cpha ? 1'b0
                                                     : first_bit(cur.tx_data, wide, lsb);
                    next_cur.state   = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (!selected) begin
                    // Partial word is dropped
                    next_cur.state    = ST_IDLE;
                    next_cur.edge_cnt = '0;
                end else if (sck_edge) begin
                    next_cur.edge_cnt = edge_num;
                    if (!cur.ctrl.cpha) begin
                        if (odd_edge) begin
                            next_cur.latched = serial_in;
                        end else begin
                            next_cur.shreg   = shifted;
                            next_cur.out_bit = first_bit(shifted, wide, lsb);
                            finished         = (edge_num == last_edge);
                        end
                    end else begin
                        if (odd_edge) begin
                            if (edge_num == 6'h01) begin
                                next_cur.out_bit = first_bit(cur.shreg, wide, lsb);
                            end else begin
                                next_cur.shreg   = shifted;
                                next_cur.out_bit = first_bit(shifted, wide, lsb);
                            end
                        end else begin
                            next_cur.latched = serial_in;
                            if (edge_num == last_edge) begin
                                // Last sample goes straight in to close the word
                                next_cur.shreg = shift_in(cur.shreg, serial_in, wide, lsb);
                                finished       = 1'b1;
                            end
                        end
                    end
                    if (finished) begin
                        // Shift register keeps the received word for the next word
                        next_cur.rx_data  = next_cur.shreg & word_mask;
                        next_cur.edge_cnt = '0;
                        if (cur.ctrl.cpha) begin
                            next_cur.out_bit = first_bit(next_cur.shreg, wide, lsb);
                        end
                    end
                end
            end
            default: begin
                next_cur.state    = ST_IDLE;
                next_cur.edge_cnt = '0;
            end
        endcase

        // ======================================================
        // Register port
        if (we) begin
            case (addr)
                // Select sequencing as a master is not built; its enable is only stored
                OFF_CONTROL: next_cur.ctrl    = ctrl_t'(wdata[CTRL_W-1:0]);
                OFF_DATA:    next_cur.tx_data = wdata[WORD_MAX-1:0];
                default:     next_cur.ctrl    = cur.ctrl;
            endcase
        end

        next_cur.rdata = '0;
        if (re) begin
            case (addr)
                OFF_CONTROL: next_cur.rdata[CTRL_W-1:0]   = cur.ctrl;
                OFF_DATA:    next_cur.rdata[WORD_MAX-1:0] = cur.rx_data;
                OFF_STATUS: begin
                    next_cur.rdata[POS_DONE] = cur.done;
                    next_cur.rdata[POS_BUSY] = (cur.state == ST_ACTIVE);
                end
                default:     next_cur.rdata = '0;
            endcase
        end

        // Reading the data clears the flag; a finishing word wins
        if (re && addr == OFF_DATA) begin
            next_cur.done = 1'b0;
        end
        if (finished) begin
            next_cur.done = 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur          <= '0;
            cur.state    <= ST_IDLE;
            cur.ctrl     <= ctrl_t'(CTRL_RESET);
            cur.tx_data  <= DATA_RESET;
            cur.rx_data  <= DATA_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // Outputs
    assign rdata              = cur.rdata;
    assign miso_o             = cur.drive ? cur.out_bit : 1'b0;
    assign miso_oe_n          = !cur.drive;
    assign transfer_done_flag = cur.done;

endmodule

//--- verification/spi_slave_checker.sv
/* Port-level assertions for the serial slave.
   Assumes one clock domain and is bound into each spi_slave_transfer. */
`timescale 1ns/1ns
module spi_slave_checker
    import spi_slave_pkg::*;
#(
    parameter int WORD_W = WORD_MAX
) (
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              we,
    input wire logic              re,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              sck,
    input wire logic              ss_n,
    input wire logic              mosi,
    input wire logic              miso_i,
    input wire logic              miso_o,
    input wire logic              miso_oe_n,
    input wire logic              transfer_done_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Select and pin release
    sequence s_deselect; $rose(ss_n); endsequence
    sequence s_release; ##[1:4] miso_oe_n; endsequence
    property p_release; s_deselect |-> s_release; endproperty
    a_release: assert property (p_release) else $error("pin not released");
    property p_idle_off; ss_n [*5] |-> miso_oe_n; endproperty
    a_idle_off: assert property (p_idle_off) else $error("pin driven while idle");
    property p_quiet; ss_n [*5] |=> $stable(miso_o); endproperty
    a_quiet: assert property (p_quiet) else $error("output moved while idle");
    property p_zero_off; miso_oe_n |-> !miso_o; endproperty
    a_zero_off: assert property (p_zero_off) else $error("output not zero when off");
    // ==========================================================
    // Completion flag and read port
    property p_flag_sel; $rose(transfer_done_flag) |-> !$past(ss_n, 2); endproperty
    a_flag_sel: assert property (p_flag_sel) else $error("flag set while idle");
    property p_sticky; transfer_done_flag && !(re && addr == OFF_DATA) |=> transfer_done_flag; endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_clear; ss_n && re && addr == OFF_DATA |=> !transfer_done_flag; endproperty
    a_clear: assert property (p_clear) else $error("flag kept after read");
    property p_rd_idle; !re |=> rdata == '0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_status; re && addr == OFF_STATUS |=> rdata[POS_DONE] == $past(transfer_done_flag); endproperty
    a_status: assert property (p_status) else $error("status flag wrong");
endmodule
bind spi_slave_transfer spi_slave_checker #(.WORD_W(WORD_W)) chk (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .we(we), .re(re), .rdata(rdata), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_i(miso_i),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .transfer_done_flag(transfer_done_flag));

//--- verification/spi_master_model.sv
/* Behavioural serial master driving clock, select and data.
   Assumes a half period of 40 ns and a resolved miso line. */
`timescale 1ns/1ns
module spi_master_model (
    output logic      sck,
    output logic      ss_n,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // Runs e edges of an n-bit word, msb first on the wire
    task xfer(input logic ph, input logic pol, input int n, input logic [15:0] tx,
              input logic hold, input int e, output logic [15:0] rx);
        // Step off the module clock edge so pin changes never race the sampling flops
        #2;
        rx = 16'h0000;
        if (ss_n) begin
            sck = pol;
            #80;
            ss_n = 1'b0;
        end
        if (!ph) mosi = tx[n-1];
        #40;
        for (int i = 1; i <= e; i++) begin
            sck = ~sck;
            if (i[0] != ph) rx = {rx[14:0], miso};
            else if (i / 2 < n) mosi = tx[n-1-i/2];
            #40;
        end
        if (!hold || e < 2 * n) begin
            ss_n = 1'b1;
            mosi = ~mosi;
            #80;
        end
    endtask
    task wiggle(input int k);
        repeat (k) begin
            #40 sck = ~sck;
        end
    endtask
endmodule

//--- verification/spi_slave_transfer_tb_top.sv
/* Self-checking bench for the serial slave.
   Assumes the master model as far side and the register port map. */
`timescale 1ns/1ns
module spi_slave_transfer_tb_top
    import spi_slave_pkg::*;
;
    logic              clk, arst_n, we, re, sck, ss_n, mosi, miso_o, miso_oe_n, done_flag, miso_line, drove;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic [15:0]       got, txs, txm, msk;
    int                fails, compares, n;
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, e, a); end end
    assign miso_line = miso_oe_n ? ~miso_o : miso_o;
    always @(negedge miso_oe_n) drove = 1'b1;
    spi_slave_transfer dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_i(miso_line), .miso_o(miso_o),
        .miso_oe_n(miso_oe_n), .transfer_done_flag(done_flag));
    spi_master_model m0 (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso_line));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    function automatic logic [15:0] rev(input logic [15:0] w, input int k);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < k; i++) r[i] = w[k-1-i];
        return r;
    endfunction
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    task test_done;
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        test_done;
    end
    // ==========================================================
    // Tests
    initial begin
        {addr, wdata, we, re, arst_n, fails, compares, drove} = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFF_CONTROL, v); `CHK("control", 32'h0, v)
        rd(OFF_STATUS, v); `CHK("status", 32'h0, v)
        rd(8'h0c, v); `CHK("unmapped", 32'h0, v)
        `CHK("oe_n", 1'b1, miso_oe_n)
        for (int m = 0; m < 16; m++) begin
            n = m[2] ? 16 : 8;
            msk = m[2] ? 16'hffff : 16'h00ff;
            txs = 16'h9a61 + m;
            txm = 16'h3cb7 - m;
            wr(OFF_CONTROL, (m[0] << POS_CPHA) | (m[1] << POS_CPOL) | (m[2] << POS_WORD_WIDTH)
                | (m[3] << POS_LSB_FIRST));
            wr(OFF_DATA, txs);
            m0.xfer(m[0], m[1], n, m[3] ? rev(txm, n) : txm, 1'b0, 2 * n, got);
            if (m[3]) got = rev(got, n);
            `CHK("flag pin", 1'b1, done_flag)
            `CHK("tx word", txs & msk, got & msk)
            rd(OFF_STATUS, v); `CHK("done", 32'h1, v)
            rd(OFF_DATA, v); `CHK("rx word", txm & msk, v[15:0] & msk)
            rd(OFF_STATUS, v); `CHK("cleared", 32'h0, v)
        end
        wr(OFF_CONTROL, 32'h1);
        drove = 1'b0;
        m0.xfer(1'b0, 1'b0, 8, 16'h00a5, 1'b0, 16, got);
        `CHK("drove", 1'b0, drove)
        rd(OFF_STATUS, v); `CHK("no word", 32'h0, v)
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_DATA, 32'h00c6);
        m0.xfer(1'b0, 1'b0, 8, 16'h00ff, 1'b0, 7, got);
        m0.wiggle(5);
        rd(OFF_STATUS, v); `CHK("aborted", 32'h0, v)
        m0.xfer(1'b0, 1'b0, 8, 16'h0033, 1'b0, 16, got);
        `CHK("after abort", 8'hc6, got[7:0])
        rd(OFF_DATA, v); `CHK("rx clean", 16'h0033, v[15:0])
        wr(OFF_DATA, 32'h0042);
        m0.xfer(1'b0, 1'b0, 8, 16'h005e, 1'b1, 16, got); `CHK("held 1", 8'h42, got[7:0])
        m0.xfer(1'b0, 1'b0, 8, 16'h0017, 1'b1, 16, got); `CHK("held 2", 8'h5e, got[7:0])
        m0.xfer(1'b0, 1'b0, 8, 16'h0069, 1'b0, 16, got); `CHK("held 3", 8'h17, got[7:0])
        m0.xfer(1'b0, 1'b0, 8, 16'h0000, 1'b0, 16, got); `CHK("reload", 8'h42, got[7:0])
        // Single-wire, driving: the slave hears its own pin, so it receives what it sends
        wr(OFF_CONTROL, 32'h60);
        wr(OFF_DATA, 32'h005a);
        m0.xfer(1'b0, 1'b0, 8, 16'h00ff, 1'b0, 16, got); `CHK("one wire tx", 8'h5a, got[7:0])
        rd(OFF_DATA, v); `CHK("one wire rx", 16'h005a, v[15:0])
        test_done;
    end
endmodule
